// ### rtl/dosel_pkg.sv
`default_nettype none
package dosel_pkg;
  // Terminal order inside the block
  localparam int NUM_TERM    = 4;
  localparam int TERM_OC     = 0;
  localparam int TERM_FAST   = 1;
  localparam int TERM_RELAY1 = 2;
  localparam int TERM_RELAY2 = 3;
  localparam int SEL_W       = 6;
  localparam int DLY_W       = 16;
  localparam int NUM_CODES   = 64;
  localparam int NUM_CARD    = 7;

  // Timing
  localparam int CLK_HZ            = 10_000_000;
  localparam int DELAY_RES_MS      = 1;
  localparam int INDEX_HOLD_MS     = 10;
  localparam int MS_CYCLES         = CLK_HZ / 1000 * DELAY_RES_MS;
  localparam int INDEX_HOLD_CYCLES = CLK_HZ / 1000 * INDEX_HOLD_MS;
  localparam logic [15:0] DELAY_MAX_MS = 16'hc350;

  // Register byte offsets
  localparam logic [7:0] ADDR_SEL    = 8'h00;
  localparam logic [7:0] ADDR_POL    = 8'h10;
  localparam logic [7:0] ADDR_FTYPE  = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  localparam logic [7:0] ADDR_DLY    = 8'h20;

  // Reset values
  localparam logic [5:0] SEL_RST [NUM_TERM] = '{6'h00, 6'h00, 6'h01, 6'h05};
  localparam logic [3:0]  POL_RST   = 4'h0;
  localparam logic        FTYPE_RST = 1'h0;
  localparam logic [15:0] DLY_RST   = 16'h0000;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // Selection codes
  localparam int CODE_IDLE = 0;
  localparam int CODE_RUN = 1;
  localparam int CODE_FWD = 2;
  localparam int CODE_REV = 3;
  localparam int CODE_JOG = 4;
  localparam int CODE_FAULT = 5;
  localparam int CODE_FLD1 = 6;
  localparam int CODE_FLD2 = 7;
  localparam int CODE_FREACH = 8;
  localparam int CODE_ZERO = 9;
  localparam int CODE_UPPER = 10;
  localparam int CODE_LOWER = 11;
  localparam int CODE_READY = 12;
  localparam int CODE_PREEX = 13;
  localparam int CODE_OVL = 14;
  localparam int CODE_UNL = 15;
  localparam int CODE_STAGE = 16;
  localparam int CODE_CYCLE = 17;
  localparam int CODE_V_MB = 23;
  localparam int CODE_V_CAN = 24;
  localparam int CODE_V_ETH = 25;
  localparam int CODE_DCBUS = 26;
  localparam int CODE_INDEX = 27;
  localparam int CODE_SUPER = 28;
  localparam int CODE_STO = 29;
  localparam int CODE_POS = 30;
  localparam int CODE_SPZ = 31;
  localparam int CODE_SPDIV = 32;
  localparam int CODE_FLIM = 33;
  localparam int CODE_V_FB = 34;
  localparam int CODE_SWITCH = 36;
  localparam int CODE_ANYF = 37;
  localparam int CODE_CARD = 41;
  localparam int CODE_OH_A = 48;
  localparam int CODE_OH_B = 49;
  localparam int CODE_OH_AIO = 50;
  localparam int CODE_STOPPED = 51;
  localparam int CODE_DISC = 52;
  localparam int CODE_ROLL_SET = 53;
  localparam int CODE_ROLL_MAX = 54;
  localparam int CODE_ROLL_MIN = 55;
  localparam int CODE_FIRE = 56;
  localparam int CODE_RSV_HI = 57;
endpackage
`default_nettype wire

// ### rtl/digital_output_function_select.sv
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
`default_nettype none
module digital_output_function_select #(
  parameter int unsigned MS_CYCLES         = dosel_pkg::MS_CYCLES,
  parameter int unsigned INDEX_HOLD_CYCLES = dosel_pkg::INDEX_HOLD_CYCLES
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Register bus
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Run state
  input  wire logic        drive_running,
  input  wire logic        freq_active,
  input  wire logic        dir_reverse,
  input  wire logic        jogging,
  input  wire logic        drive_fault,
  input  wire logic        freq_level_detect_one,
  input  wire logic        freq_level_detect_two,
  input  wire logic        freq_reached,
  input  wire logic        out_freq_zero,
  input  wire logic        ref_freq_zero,
  input  wire logic        at_upper_limit,
  input  wire logic        at_lower_limit,
  input  wire logic        main_power_ok,
  input  wire logic        ctrl_power_ok,
  input  wire logic        protection_active,
  input  wire logic        ready_to_run,
  input  wire logic        pre_exciting,
  input  wire logic        overload_prealarm,
  input  wire logic        underload_prealarm,
  input  wire logic        seq_stage_done,
  input  wire logic        seq_cycle_done,
  // Virtual fieldbus bits, one per terminal
  input  wire logic [3:0]  virt_modbus,
  input  wire logic [3:0]  virt_canopen,
  input  wire logic [3:0]  virt_ethernet,
  input  wire logic [3:0]  virt_fieldbus,
  // Motion and protection
  input  wire logic        dc_bus_ok,
  input  wire logic        enc_index,
  input  wire logic        pulse_superpos,
  input  wire logic        safe_torque_off,
  input  wire logic        positioning_done,
  input  wire logic        spindle_zero_done,
  input  wire logic        spindle_div_done,
  input  wire logic        freq_limited,
  input  wire logic        mode_switch_done,
  input  wire logic        ramp_above_detect,
  input  wire logic [6:0]  expansion_card_out,
  input  wire logic        overheat_card_a,
  input  wire logic        overheat_card_b,
  input  wire logic        overheat_analog_io_channel,
  input  wire logic        drive_stopped,
  input  wire logic        zero_speed,
  input  wire logic        tension_disconnect,
  input  wire logic        roll_set_reached,
  input  wire logic        roll_max_reached,
  input  wire logic        roll_min_reached,
  input  wire logic        fire_mode,
  // Pulse train from the pulse generator
  input  wire logic        pulse_train_in,
  // Terminals
  output logic             open_collector_output,
  output logic             fast_pulse_output,
  output logic             relay_output_one,
  output logic             relay_output_two
);

  localparam int NT = dosel_pkg::NUM_TERM;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  logic [5:0]  sel_ff [NT];
  logic [15:0] dly_on_ff [NT];
  logic [15:0] dly_off_ff [NT];
  logic [3:0]  pol_ff;
  logic        fast_type_ff;
  logic [7:0]  awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0]  wstrb_ff;
  logic        aw_got_ff;
  logic        w_got_ff;
  logic [23:0] ms_cnt_ff;
  logic [23:0] z_cnt_ff;
  logic        ms_tick;
  logic        z_active;
  logic        wr_fire;
  logic [31:0] wr_cur;
  logic        wr_ok;
  logic [31:0] wr_val;
  logic [31:0] rd_val;
  logic        rd_ok;
  logic [63:0] common;
  logic [3:0]  routed;
  logic [3:0]  target;
  logic [3:0]  level;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nd,
                                        input logic [3:0]  s);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (s[b]) begin
        r[8*b +: 8] = nd[8*b +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [15:0] clamp_ms(input logic [31:0] v);
    logic [15:0] r;
    r = v[15:0];
    if (v > {16'h0000, dosel_pkg::DELAY_MAX_MS}) begin
      r = dosel_pkg::DELAY_MAX_MS;
    end
    return r;
  endfunction

  // Decoded register read, shared by the read channel and merges
  function automatic logic [32:0] reg_word(input logic [7:0] a);
    logic [32:0] r;
    r = {1'b1, 32'h0000_0000};
    if (a[7:4] == dosel_pkg::ADDR_SEL[7:4]) begin
      r[5:0] = sel_ff[a[3:2]];
    end else if (a[7:2] == dosel_pkg::ADDR_POL[7:2]) begin
      r[3:0] = pol_ff;
    end else if (a[7:2] == dosel_pkg::ADDR_FTYPE[7:2]) begin
      r[0] = fast_type_ff;
    end else if (a[7:2] == dosel_pkg::ADDR_STATUS[7:2]) begin
      r[7:0] = {level, target};
    end else if (a[7:5] == dosel_pkg::ADDR_DLY[7:5]) begin
      r[15:0] = a[2] ? dly_off_ff[a[4:3]] : dly_on_ff[a[4:3]];
    end else begin
      r[32] = 1'b0;
    end
    return r;
  endfunction

  // Write channel: address and data taken in either order
  assign awready = !aw_got_ff && !bvalid;
  assign wready  = !w_got_ff && !bvalid;
  assign wr_fire = aw_got_ff && w_got_ff && !bvalid;
  assign arready = !rvalid;

  always_comb begin
    {wr_ok, wr_cur} = reg_word(awaddr_ff);
    if (awaddr_ff[7:2] == dosel_pkg::ADDR_STATUS[7:2]) begin
      wr_ok = 1'b0;
    end
    wr_val = merge(wr_cur, wdata_ff, wstrb_ff);
    {rd_ok, rd_val} = reg_word(araddr);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_ff <= 1'b0;
      w_got_ff  <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff  <= 32'h0000_0000;
      wstrb_ff  <= 4'h0;
      bvalid    <= 1'b0;
      bresp     <= dosel_pkg::RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= awaddr;
      end
      if (wvalid && wready) begin
        w_got_ff <= 1'b1;
        wdata_ff <= wdata;
        wstrb_ff <= wstrb;
      end
      if (wr_fire) begin
        aw_got_ff <= 1'b0;
        w_got_ff  <= 1'b0;
        bvalid    <= 1'b1;
        bresp     <= wr_ok ? dosel_pkg::RESP_OKAY : dosel_pkg::RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= dosel_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= rd_val;
      rresp  <= rd_ok ? dosel_pkg::RESP_OKAY : dosel_pkg::RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

  // Configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < NT; i++) begin
        sel_ff[i]     <= dosel_pkg::SEL_RST[i];
        dly_on_ff[i]  <= dosel_pkg::DLY_RST;
        dly_off_ff[i] <= dosel_pkg::DLY_RST;
      end
      pol_ff       <= dosel_pkg::POL_RST;
      fast_type_ff <= dosel_pkg::FTYPE_RST;
    end else if (wr_fire && wr_ok) begin
      if (awaddr_ff[7:4] == dosel_pkg::ADDR_SEL[7:4]) begin
        sel_ff[awaddr_ff[3:2]] <= wr_val[5:0];
      end
      if (awaddr_ff[7:2] == dosel_pkg::ADDR_POL[7:2]) begin
        pol_ff <= wr_val[3:0];
      end
      if (awaddr_ff[7:2] == dosel_pkg::ADDR_FTYPE[7:2]) begin
        fast_type_ff <= wr_val[0];
      end
      if (awaddr_ff[7:5] == dosel_pkg::ADDR_DLY[7:5]) begin
        if (awaddr_ff[2]) begin
          dly_off_ff[awaddr_ff[4:3]] <= clamp_ms(wr_val);
        end else begin
          dly_on_ff[awaddr_ff[4:3]] <= clamp_ms(wr_val);
        end
      end
    end
  end

  assign ms_tick = (ms_cnt_ff == 24'(MS_CYCLES - 1));

  always_ff @(posedge aclk) begin
    if (!aresetn || ms_tick) begin
      ms_cnt_ff <= 24'h000000;
    end else begin
      ms_cnt_ff <= ms_cnt_ff + 24'h000001;
    end
  end

  // index pulse stretch, retriggers on a new index
  assign z_active = (z_cnt_ff != 24'h000000);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      z_cnt_ff <= 24'h000000;
    end else if (enc_index) begin
      z_cnt_ff <= 24'(INDEX_HOLD_CYCLES);
    end else if (z_active) begin
      z_cnt_ff <= z_cnt_ff - 24'h000001;
    end
  end

  // Conditions shared by all terminals; reserved codes stay low
  always_comb begin
    // code zero and reserved codes are never set
    common = '0;
    common[dosel_pkg::CODE_RUN] = drive_running && freq_active;
    common[dosel_pkg::CODE_FWD] = drive_running && freq_active
                                  && !dir_reverse;
    common[dosel_pkg::CODE_REV] = drive_running && freq_active
                                  && dir_reverse;
    common[dosel_pkg::CODE_JOG] = drive_running && freq_active && jogging;
    common[dosel_pkg::CODE_FAULT] = drive_fault;
    common[dosel_pkg::CODE_FLD1]   = freq_level_detect_one;
    common[dosel_pkg::CODE_FLD2]   = freq_level_detect_two;
    common[dosel_pkg::CODE_FREACH] = freq_reached;
    common[dosel_pkg::CODE_ZERO] = out_freq_zero && ref_freq_zero;
    common[dosel_pkg::CODE_UPPER] = at_upper_limit;
    common[dosel_pkg::CODE_LOWER] = at_lower_limit;
    common[dosel_pkg::CODE_READY] = main_power_ok && ctrl_power_ok
                                    && !protection_active && ready_to_run;
    common[dosel_pkg::CODE_PREEX] = pre_exciting;
    common[dosel_pkg::CODE_OVL] = overload_prealarm;
    common[dosel_pkg::CODE_UNL] = underload_prealarm;
    common[dosel_pkg::CODE_STAGE] = seq_stage_done;
    common[dosel_pkg::CODE_CYCLE] = seq_cycle_done;
    common[dosel_pkg::CODE_DCBUS] = dc_bus_ok;
    common[dosel_pkg::CODE_INDEX] = z_active;
    common[dosel_pkg::CODE_SUPER] = pulse_superpos;
    common[dosel_pkg::CODE_STO] = safe_torque_off;
    common[dosel_pkg::CODE_POS]   = positioning_done;
    common[dosel_pkg::CODE_SPZ]   = spindle_zero_done;
    common[dosel_pkg::CODE_SPDIV] = spindle_div_done;
    common[dosel_pkg::CODE_FLIM]   = freq_limited;
    common[dosel_pkg::CODE_SWITCH] = mode_switch_done;
    common[dosel_pkg::CODE_ANYF] = ramp_above_detect;
    for (int k = 0; k < dosel_pkg::NUM_CARD; k++) begin
      common[dosel_pkg::CODE_CARD + k] = expansion_card_out[k];
    end
    common[dosel_pkg::CODE_OH_A]   = overheat_card_a;
    common[dosel_pkg::CODE_OH_B]   = overheat_card_b;
    common[dosel_pkg::CODE_OH_AIO] = overheat_analog_io_channel;
    common[dosel_pkg::CODE_STOPPED] = drive_stopped || zero_speed;
    common[dosel_pkg::CODE_DISC]     = tension_disconnect;
    common[dosel_pkg::CODE_ROLL_SET] = roll_set_reached && drive_running;
    common[dosel_pkg::CODE_ROLL_MAX] = roll_max_reached && drive_running;
    common[dosel_pkg::CODE_ROLL_MIN] = roll_min_reached && drive_running;
    common[dosel_pkg::CODE_FIRE]     = fire_mode;
  end

  // One routing and delay slice per terminal
  for (genvar t = 0; t < NT; t++) begin : g_term
    logic [63:0] cond;
    logic [15:0] cnt_ff;
    logic        lvl_ff;
    logic [15:0] dly;

    always_comb begin
      cond = common;
      cond[dosel_pkg::CODE_V_MB]  = virt_modbus[t];
      cond[dosel_pkg::CODE_V_CAN] = virt_canopen[t];
      cond[dosel_pkg::CODE_V_ETH] = virt_ethernet[t];
      cond[dosel_pkg::CODE_V_FB]  = virt_fieldbus[t];
    end

    // each terminal selects on its own
    assign routed[t] = cond[sel_ff[t]];
    assign target[t] = routed[t] ^ pol_ff[t];
    assign dly       = target[t] ? dly_on_ff[t] : dly_off_ff[t];
    assign level[t]  = lvl_ff;

    // a change must persist for the whole delay
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        cnt_ff <= 16'h0000;
        lvl_ff <= 1'b0;
      end else if (target[t] == lvl_ff) begin
        cnt_ff <= 16'h0000;
      end else if (cnt_ff >= dly) begin
        cnt_ff <= 16'h0000;
        lvl_ff <= target[t];
      end else if (ms_tick) begin
        cnt_ff <= cnt_ff + 16'h0001;
      end
    end

    a_idle_code: assert property (
      sel_ff[t] == 6'(dosel_pkg::CODE_IDLE) |-> !routed[t])
      else $error("idle code routed a level");
    a_reserved_idle: assert property (
      sel_ff[t] >= 6'(dosel_pkg::CODE_RSV_HI) |-> !routed[t])
      else $error("reserved code routed a level");
    a_fault_route: assert property (
      sel_ff[t] == 6'(dosel_pkg::CODE_FAULT) |-> routed[t] == drive_fault)
      else $error("fault code does not follow fault");
    a_zero_route: assert property (
      sel_ff[t] == 6'(dosel_pkg::CODE_ZERO)
      |-> routed[t] == (out_freq_zero && ref_freq_zero))
      else $error("zero speed code wrong");
    a_no_delay_follow: assert property (
      (target[t] != lvl_ff && dly == 16'h0000)
      |=> lvl_ff == $past(target[t]))
      else $error("zero delay did not pass level");
    a_polarity_idle: assert property (
      (sel_ff[t] == 6'(dosel_pkg::CODE_IDLE) && pol_ff[t]
       && dly_on_ff[t] == 16'h0000) [*3] |-> lvl_ff)
      else $error("inverted idle terminal not on");
  end

  // Pins; the fast terminal may carry the pulse train instead
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      open_collector_output <= 1'b0;
      fast_pulse_output     <= 1'b0;
      relay_output_one      <= 1'b0;
      relay_output_two      <= 1'b0;
    end else begin
      open_collector_output <= level[dosel_pkg::TERM_OC];
      fast_pulse_output <= fast_type_ff ? level[dosel_pkg::TERM_FAST]
                                        : pulse_train_in;
      relay_output_one <= level[dosel_pkg::TERM_RELAY1];
      relay_output_two <= level[dosel_pkg::TERM_RELAY2];
    end
  end

  a_index_start: assert property (
    enc_index |=> z_active ##0 z_cnt_ff == 24'(INDEX_HOLD_CYCLES))
    else $error("index did not start hold");
  a_index_end: assert property (
    (z_cnt_ff == 24'h000001 && !enc_index) |=> !z_active)
    else $error("index hold did not end");
  a_fast_type: assert property (
    !fast_type_ff |=> fast_pulse_output == $past(pulse_train_in))
    else $error("pulse type not passing pulse train");
  a_shared_code: assert property (
    (sel_ff[0] == 6'(dosel_pkg::CODE_FAULT)
     && sel_ff[3] == 6'(dosel_pkg::CODE_FAULT)) |-> routed[0] == routed[3])
    else $error("shared code diverged");
  a_bresp_hold: assert property (
    (bvalid && !bready) |=> bvalid && $stable(bresp))
    else $error("write response dropped");

  c_relay_fault: cover property (
    sel_ff[3] == 6'(dosel_pkg::CODE_FAULT) && drive_fault ##1 target[3]);
  c_index_hold: cover property (enc_index ##1 z_active [*3]);
  c_wr_then_rd: cover property (bvalid && bready ##[1:4] rvalid);

endmodule
`default_nettype wire

// ### testbench/term_load.sv
`default_nettype none
module term_load (
  // Terminal drive
  input  wire logic [3:0] drive,
  // Load state
  output logic [3:0]      energized
);
  timeunit 1ns;
  timeprecision 1ns;
  // No contact bounce, so pin and load agree at once
  assign energized = drive;
endmodule
`default_nettype wire

// ### testbench/digital_output_function_select_test.sv
`default_nettype none
module digital_output_function_select_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [1:0] OK  = dosel_pkg::RESP_OKAY;
  localparam logic [1:0] ERR = dosel_pkg::RESP_SLVERR;
  int          errors;
  int          checks_done;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid;
  logic        bready, arvalid, arready, rvalid, rready, pulse_train_in;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [3:0]  wstrb, virt_modbus, virt_canopen, virt_ethernet;
  logic [3:0]  virt_fieldbus, energized;
  logic [6:0]  expansion_card_out;
  logic        open_collector_output, fast_pulse_output, relay_output_one;
  logic        relay_output_two, drive_running, freq_active, dir_reverse;
  logic        jogging, drive_fault, freq_level_detect_one, freq_reached;
  logic        freq_level_detect_two, out_freq_zero, ref_freq_zero;
  logic        at_upper_limit, at_lower_limit, main_power_ok, ctrl_power_ok;
  logic        protection_active, ready_to_run, pre_exciting, dc_bus_ok;
  logic        overload_prealarm, underload_prealarm, seq_stage_done;
  logic        seq_cycle_done, enc_index, pulse_superpos, safe_torque_off;
  logic        positioning_done, spindle_zero_done, spindle_div_done;
  logic        freq_limited, mode_switch_done, ramp_above_detect, zero_speed;
  logic        overheat_card_a, overheat_card_b, overheat_analog_io_channel;
  logic        drive_stopped, tension_disconnect, roll_set_reached;
  logic        roll_max_reached, roll_min_reached, fire_mode;

  digital_output_function_select #(
    .MS_CYCLES        (10),
    .INDEX_HOLD_CYCLES(50)
  ) u_dut (.*);

  term_load u_load (
    .drive    ({relay_output_two, relay_output_one, fast_pulse_output,
                open_collector_output}),
    .energized(energized)
  );

  initial begin
    aclk = 1'h0;
    forever #50 aclk = ~aclk;
  end

  task automatic all_cond(input logic v);
    {drive_running, freq_active, dir_reverse, jogging, drive_fault,
     freq_level_detect_one, freq_level_detect_two, freq_reached,
     out_freq_zero, ref_freq_zero, at_upper_limit, at_lower_limit,
     main_power_ok, ctrl_power_ok, protection_active, ready_to_run,
     pre_exciting, overload_prealarm, underload_prealarm, seq_stage_done,
     seq_cycle_done, dc_bus_ok, enc_index, pulse_superpos, safe_torque_off,
     positioning_done, spindle_zero_done, spindle_div_done, freq_limited,
     mode_switch_done, ramp_above_detect, overheat_card_a, overheat_card_b,
     overheat_analog_io_channel, drive_stopped, zero_speed,
     tension_disconnect, roll_set_reached, roll_max_reached,
     roll_min_reached, fire_mode, virt_modbus, virt_canopen, virt_ethernet,
     virt_fieldbus, expansion_card_out} <= {64{v}};
  endtask

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] r);
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= d;
    awvalid <= 1'h1;
    wvalid  <= 1'h1;
    bready  <= 1'h1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (!bvalid);
    bready <= 1'h0;
    chk("bresp", r, bresp);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] r);
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'h1;
    rready  <= 1'h1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'h0;
    end while (!rvalid);
    rready <= 1'h0;
    chk("rdata", e, rdata);
    chk("rresp", r, rresp);
  endtask

  task automatic selall(input int c);
    for (int t = 0; t < 4; t++) wr(8'(4 * t), 32'(c), OK);
  endtask

  // Condition path plus pin register is two edges
  task automatic pins(input logic [3:0] e);
    repeat (3) @(posedge aclk);
    chk("terminals", e, energized);
  endtask

  function automatic logic live(input int c);
    return !(c == 0 || c == 2 || c == 12 || (c >= 18 && c <= 22) ||
             c == 35 || (c >= 38 && c <= 40) || c >= 57);
  endfunction

  task automatic finish_test;
    if (errors == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  initial begin
    errors      = 0;
    checks_done = 0;
    aresetn        <= 1'h0;
    {awvalid, wvalid, bready, arvalid, rready} <= 5'h00;
    {awaddr, araddr, wdata} <= 48'h0;
    wstrb          <= 4'hf;
    pulse_train_in <= 1'h0;
    all_cond(1'h0);
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    for (int t = 0; t < 4; t++) rd(8'(4 * t), dosel_pkg::SEL_RST[t], OK);
    rd(dosel_pkg::ADDR_POL, 32'h0, OK);
    rd(dosel_pkg::ADDR_FTYPE, 32'h0, OK);
    wr(8'h7c, 32'h1, ERR);
    rd(8'h7c, 32'h0, ERR);
    wr(dosel_pkg::ADDR_STATUS, 32'h1, ERR);
    @(posedge aclk);
    pulse_train_in <= 1'h1;
    pins(4'h2);
    wr(dosel_pkg::ADDR_FTYPE, 32'h1, OK);
    // Sweep
    // Sweep
    // Sweep
    for (int v = 0; v < 2; v++) begin
      @(posedge aclk);
      all_cond(v[0]);
      for (int c = 0; c < 64; c++) begin
        selall(c);
        pins({4{v[0] & live(c)}});
      end
    end
    @(posedge aclk);
    dir_reverse <= 1'h0;
    selall(2);
    pins(4'hf);
    @(posedge aclk);
    freq_active <= 1'h0;
    pins(4'h0);
    selall(12);
    @(posedge aclk);
    protection_active <= 1'h0;
    pins(4'hf);
    @(posedge aclk);
    ctrl_power_ok <= 1'h0;
    pins(4'h0);
    selall(9);
    @(posedge aclk);
    ref_freq_zero <= 1'h0;
    pins(4'h0);
    @(posedge aclk);
    virt_modbus        <= 4'h5;
    expansion_card_out <= 7'h40;
    selall(23);
    pins(4'h5);
    selall(47);
    pins(4'hf);
    selall(46);
    pins(4'h0);
    wr(dosel_pkg::ADDR_POL, 32'h9, OK);
    pins(4'h9);
    selall(0);
    pins(4'h9);
    rd(dosel_pkg::ADDR_STATUS, 32'h99, OK);
    wr(dosel_pkg::ADDR_POL, 32'h0, OK);
    @(posedge aclk);
    drive_fault <= 1'h0;
    enc_index   <= 1'h0;
    selall(5);
    wr(8'h38, 32'hea60, OK);
    rd(8'h38, 32'hc350, OK);
    // Byte lane merge on a partial write
    wstrb <= 4'h1;
    wr(8'h38, 32'h3, OK);
    rd(8'h38, 32'hc303, OK);
    wstrb <= 4'hf;
    wr(8'h38, 32'h3, OK);
    wr(8'h08, 32'h1b, OK);
    @(posedge aclk);
    drive_fault <= 1'h1;
    repeat (15) @(posedge aclk);
    chk("on delay", 32'h0, energized[3]);
    repeat (20) @(posedge aclk);
    chk("on delay", 32'h1, energized[3]);
    drive_fault <= 1'h0;
    repeat (3) @(posedge aclk);
    chk("off delay", 32'h0, energized[3]);
    repeat (60) @(posedge aclk);
    enc_index <= 1'h1;
    @(posedge aclk);
    enc_index <= 1'h0;
    repeat (40) @(posedge aclk);
    chk("index hold", 32'h1, energized[2]);
    repeat (20) @(posedge aclk);
    chk("index hold", 32'h0, energized[2]);
    // Mid-run reset brings back defaults
    aresetn <= 1'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'h1;
    pins(4'h2);
    rd(8'h38, 32'h0, OK);
    rd(8'h08, 32'h1, OK);
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge aclk);
    errors++;
    finish_test();
  end
endmodule
`default_nettype wire
